// [core/scsc_pkg.sv]
// constants and types shared by the system clock and standby controller
package scsc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] SCSC_IDX_ONE = 8'h38;
  localparam logic [7:0] SCSC_IDX_TWO = 8'h39;
  localparam logic [7:0] SCSC_IDX_DIV = 8'h3A;
  localparam logic [7:0] SCSC_IDX_STATUS = 8'h3B;
  localparam int SCSC_ADDR_W = 10;
  // reset values
  localparam logic [7:0] SCSC_RST_ONE = 8'h00;
  localparam logic [7:0] SCSC_RST_TWO = 8'h80;
  localparam logic [7:0] SCSC_RST_DIV = 8'h02;
  // field positions
  localparam int SCSC_STOP_BIT = 7;
  localparam int SCSC_RELEASE_METHOD_BIT = 6;
  localparam int SCSC_WUT_LO = 2;
  localparam int SCSC_IDLE_BIT = 4;
  localparam int SCSC_DIVIDER_FIRST_STAGE_SELECT_BIT = 4;
  // clock chain
  localparam int SCSC_PRESCALE = 3;
  localparam int SCSC_DIV_STAGES = 21;
  localparam int SCSC_FEED_STAGE = 7;
  localparam int SCSC_FEED_LOG2 = 8;
  localparam int SCSC_MC_STATES = 4;
  localparam logic [1:0] SCSC_FC8_HALF = 2'h2;
  localparam logic [1:0] SCSC_FC8_FULL = 2'h0;
  // warm-up: multiples of the 2^14 unit for select 00..11
  localparam int SCSC_WU_UNIT = 16384;
  localparam int SCSC_WU_MUL0 = 12;
  localparam int SCSC_WU_MUL1 = 4;
  localparam int SCSC_WU_MUL2 = 3;
  localparam int SCSC_WU_MUL3 = 1;
  localparam int SCSC_WU_W = 20;
  // axi responses
  localparam logic [1:0] SCSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCSC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SCSC_NORMAL, SCSC_IDLE, SCSC_STOP, SCSC_WARMUP
  } scsc_mode_t;
endpackage : scsc_pkg

// [core/scsc_divider.sv]
// prescaler and divider chain of the timing generator
`timescale 1ns/1ps
module scsc_divider
  import scsc_pkg::*;
(
  input wire logic aclk, // oscillator clock
  input wire logic aresetn, // sync reset, low
  input wire logic clear, // clear divider stages
  input wire logic run, // oscillator running
  output logic [1:0] prescale_q, // prescaler count
  output logic [SCSC_DIV_STAGES-1:0] div_q // divider stages
);
  logic [SCSC_FEED_LOG2-1:0] feed_cnt;
  localparam int LOW_W = SCSC_FEED_STAGE - 1;

  // prescaler is only cleared by reset, so it keeps phase over STOP
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_q <= 2'h0;
    end else if (run) begin
      if (prescale_q == 2'(SCSC_PRESCALE - 1)) prescale_q <= 2'h0;
      else prescale_q <= prescale_q + 2'h1;
    end
  end

  // first six stages from prescaler, seventh onward from fc/256
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      div_q <= '0;
      feed_cnt <= '0;
    end else if (run) begin
      feed_cnt <= feed_cnt + 1'b1;
      if (prescale_q == 2'(SCSC_PRESCALE - 1))
        div_q[LOW_W-1:0] <= div_q[LOW_W-1:0] + 1'b1;
      if (&feed_cnt)
        div_q[SCSC_DIV_STAGES-1:LOW_W] <=
          div_q[SCSC_DIV_STAGES-1:LOW_W] + 1'b1;
    end
  end
endmodule : scsc_divider

// [core/scsc_warmup.sv]
// warm-up down counter for STOP release
`timescale 1ns/1ps
module scsc_warmup
  import scsc_pkg::*;
(
  input wire logic aclk, // oscillator clock
  input wire logic aresetn, // sync reset, low
  input wire logic load, // start a warm-up
  input wire logic [SCSC_WU_W-1:0] count, // periods to wait
  output logic busy, // warm-up running
  output logic done // one-cycle end pulse
);
  logic [SCSC_WU_W-1:0] remain;

  // count down the loaded number of oscillator periods
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remain <= '0;
      busy <= 1'b0;
    end else begin
      if (load) begin
        remain <= count;
        busy <= 1'b1;
      end else if (busy) begin
        remain <= remain - 1'b1;
        if (remain == SCSC_WU_W'(1)) busy <= 1'b0;
      end
    end
  end

  // end flag on the last counted period, so the mode leaves warm-up
  // after exactly count periods and not one period late
  assign done = busy && !load && remain == SCSC_WU_W'(1);

  property p_wu_done;
    @(posedge aclk) disable iff (!aresetn)
    busy && !load && remain == SCSC_WU_W'(1) |-> done ##1 !busy && !done;
  endproperty
  a_wu_done: assert property (p_wu_done)
    else $error("warm-up end not flagged");
endmodule : scsc_warmup

// [core/scsc_top.sv]
// system clock and standby controller with axi4-lite registers
`timescale 1ns/1ps
module scsc_top
  import scsc_pkg::*;
#(
  parameter int WU_UNIT = SCSC_WU_UNIT // 2^14 warm-up periods
) (
  input wire logic aclk, // oscillator clock
  input wire logic aresetn, // sync reset, low
  input wire logic [SCSC_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [SCSC_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic stop_pin, // stop release input
  input wire logic reset_pin_n, // external reset, low
  input wire logic irq_req, // enabled interrupt pending
  input wire logic interrupt_master_enable, // core enable flag
  output logic osc_enable, // oscillator running
  output logic cpu_run, // core clocked
  output logic wdt_run, // watchdog clocked
  output logic periph_run, // peripherals clocked
  output logic [1:0] mc_state, // machine cycle state
  output logic fc8_out, // divider source output enable
  output logic irq_service, // pulse: take interrupt
  output logic resume_next, // pulse: resume next instruction
  output logic [1:0] mode // current operating mode
);
  // counter width must hold the longest doubled warm-up
  if (WU_UNIT < 1 || WU_UNIT * SCSC_WU_MUL0 * 2 >= (1 << SCSC_WU_W)) begin
    : g_bad_unit
    $error("WU_UNIT out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations
  scsc_mode_t state;
  scsc_mode_t next_state;
  logic rst_n;
  logic [7:0] sby_one;
  logic [7:0] sby_two;
  logic [7:0] div_src;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane;
  logic wr_do;
  logic wr_one;
  logic wr_two;
  logic stop_req;
  logic idle_req;
  logic pin_prev;
  logic pin_rise;
  logic wu_load;
  logic wu_busy;
  logic wu_done;
  logic div_clear;
  logic fc8_phase;
  logic [1:0] presc_q;
  logic [SCSC_DIV_STAGES-1:0] div_q;
  logic [SCSC_WU_W-1:0] wu_count;
  logic [7:0] ar_idx;

  // external reset pin acts as a synchronous reset of everything but the axi channels
  assign rst_n = aresetn && reset_pin_n;

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 8'h00;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SCSC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[SCSC_ADDR_W-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_idx == SCSC_IDX_ONE || aw_idx == SCSC_IDX_TWO ||
          aw_idx == SCSC_IDX_DIV || aw_idx == SCSC_IDX_STATUS) ?
          SCSC_RESP_OKAY : SCSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // each ready only while its own channel holds nothing and no response is pending, so one write is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid && !wr_do &&
        !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !s_axi_bvalid && !wr_do &&
        !(s_axi_wvalid && s_axi_wready);
    end
  end

  assign wr_do = aw_held && w_held && !s_axi_bvalid;
  assign wr_one = wr_do && w_lane && aw_idx == SCSC_IDX_ONE;
  assign wr_two = wr_do && w_lane && aw_idx == SCSC_IDX_TWO;
  assign stop_req = wr_one && w_byte[SCSC_STOP_BIT];
  assign idle_req = wr_two && w_byte[SCSC_IDLE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // control registers; hardware clears stop and idle bits on exit
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      sby_one <= SCSC_RST_ONE;
      sby_two <= SCSC_RST_TWO;
      div_src <= SCSC_RST_DIV;
    end else begin
      if (wu_done) sby_one[SCSC_STOP_BIT] <= 1'b0;
      if (state == SCSC_IDLE && irq_req) sby_two[SCSC_IDLE_BIT] <= 1'b0;
      // a write in the same cycle wins over the hardware clear
      if (wr_one) sby_one <= {w_byte[7:2], 2'b00};
      if (wr_two) sby_two <= {w_byte[7:4], 4'h0};
      if (wr_do && w_lane && aw_idx == SCSC_IDX_DIV) div_src <= w_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, unmapped answers slverr
  assign ar_idx = s_axi_araddr[SCSC_ADDR_W-1:2];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SCSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= SCSC_RESP_OKAY;
        case (ar_idx)
          SCSC_IDX_ONE: s_axi_rdata <= {24'h00_0000, sby_one};
          SCSC_IDX_TWO: s_axi_rdata <= {24'h00_0000, sby_two};
          SCSC_IDX_DIV: s_axi_rdata <= {24'h00_0000, div_src};
          SCSC_IDX_STATUS: s_axi_rdata <= {28'h000_0000, stop_pin,
            wu_busy, state};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SCSC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stop pin edge detect for edge-sensitive release
  always_ff @(posedge aclk) begin
    if (!rst_n) pin_prev <= 1'b0;
    else pin_prev <= stop_pin;
  end
  assign pin_rise = stop_pin && !pin_prev;

  // standby mode sequencer
  always_comb begin
    next_state = state;
    wu_load = 1'b0;
    case (state)
      SCSC_NORMAL: begin
        if (stop_req) begin
          if (w_byte[SCSC_RELEASE_METHOD_BIT] && stop_pin) begin
            next_state = SCSC_WARMUP;
            wu_load = 1'b1;
          end else begin
            next_state = SCSC_STOP;
          end
        end else if (idle_req) begin
          next_state = SCSC_IDLE;
        end
      end
      SCSC_IDLE: if (irq_req) next_state = SCSC_NORMAL;
      SCSC_STOP: begin
        // release by level when method is one, else by rising edge
        if (sby_one[SCSC_RELEASE_METHOD_BIT] ? stop_pin : pin_rise) begin
          next_state = SCSC_WARMUP;
          wu_load = 1'b1;
        end
      end
      SCSC_WARMUP: if (wu_done) next_state = SCSC_NORMAL;
      default: next_state = SCSC_NORMAL;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) state <= SCSC_NORMAL;
    else state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // warm-up length from select and first-stage select
  function automatic logic [SCSC_WU_W-1:0] wu_len(input logic [1:0] sel,
                                                  input logic dbl);
    int m;
    case (sel)
      2'h0: m = SCSC_WU_MUL0;
      2'h1: m = SCSC_WU_MUL1;
      2'h2: m = SCSC_WU_MUL2;
      default: m = SCSC_WU_MUL3;
    endcase
    return SCSC_WU_W'(m * WU_UNIT * (dbl ? 2 : 1));
  endfunction : wu_len

  // a stop write that skips to warm-up has not stored its select yet
  assign wu_count = wu_len(state == SCSC_NORMAL ?
    w_byte[SCSC_WUT_LO+1:SCSC_WUT_LO] : sby_one[SCSC_WUT_LO+1:SCSC_WUT_LO],
    div_src[SCSC_DIVIDER_FIRST_STAGE_SELECT_BIT]);

  scsc_warmup u_warmup (
    .aclk(aclk),
    .aresetn(rst_n),
    .load(wu_load),
    .count(wu_count),
    .busy(wu_busy),
    .done(wu_done)
  );

  // divider held at zero while stopped or warming up
  assign div_clear = state == SCSC_STOP || state == SCSC_WARMUP;

  scsc_divider u_divider (
    .aclk(aclk),
    .aresetn(rst_n),
    .clear(div_clear),
    .run(osc_enable),
    .prescale_q(presc_q),
    .div_q(div_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock gating outputs per mode
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      osc_enable <= 1'b1;
      cpu_run <= 1'b1;
      wdt_run <= 1'b1;
      periph_run <= 1'b1;
      mode <= 2'(SCSC_NORMAL);
    end else begin
      osc_enable <= next_state != SCSC_STOP;
      cpu_run <= next_state == SCSC_NORMAL;
      wdt_run <= next_state == SCSC_NORMAL;
      periph_run <= next_state == SCSC_NORMAL ||
        next_state == SCSC_IDLE;
      mode <= 2'(next_state);
    end
  end

  // idle exit: service the interrupt or resume the next instruction
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      irq_service <= 1'b0;
      resume_next <= 1'b0;
    end else begin
      irq_service <= state == SCSC_IDLE && irq_req &&
        interrupt_master_enable;
      resume_next <= (state == SCSC_IDLE && irq_req &&
        !interrupt_master_enable) || wu_done;
    end
  end

  // machine cycle states advance once per main clock while core runs
  always_ff @(posedge aclk) begin
    if (!rst_n) mc_state <= 2'h0;
    else if (next_state == SCSC_NORMAL)
      mc_state <= mc_state + 2'h1;
  end

  // divider source output: every clock for 00, every second for 10
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      fc8_phase <= 1'b0;
      fc8_out <= 1'b0;
    end else if (osc_enable) begin
      fc8_phase <= !fc8_phase;
      fc8_out <= (div_src[1:0] == SCSC_FC8_FULL) ||
        (div_src[1:0] == SCSC_FC8_HALF && fc8_phase);
    end else begin
      fc8_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!rst_n);

  sequence s_warm_exit;
    state == SCSC_WARMUP ##1 state == SCSC_NORMAL;
  endsequence

  property p_edge_enter;
    state == SCSC_NORMAL && stop_req && !w_byte[SCSC_RELEASE_METHOD_BIT]
      |=> state == SCSC_STOP ##1 !osc_enable;
  endproperty
  a_edge_enter: assert property (p_edge_enter)
    else $error("edge mode did not enter stop");

  property p_level_skip;
    state == SCSC_NORMAL && stop_req && w_byte[SCSC_RELEASE_METHOD_BIT] && stop_pin
      |=> state == SCSC_WARMUP && osc_enable;
  endproperty
  a_level_skip: assert property (p_level_skip)
    else $error("level mode with pin high entered stop");

  property p_level_release;
    state == SCSC_STOP && sby_one[SCSC_RELEASE_METHOD_BIT] && stop_pin
      |=> state == SCSC_WARMUP;
  endproperty
  a_level_release: assert property (p_level_release)
    else $error("level release missed");

  property p_edge_hold;
    state == SCSC_STOP && !sby_one[SCSC_RELEASE_METHOD_BIT] && !pin_rise
      |=> state == SCSC_STOP;
  endproperty
  a_edge_hold: assert property (p_edge_hold)
    else $error("stop left without rising edge");

  property p_osc_off;
    state == SCSC_STOP |-> !osc_enable && !cpu_run && !periph_run;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("clocks running in stop");

  property p_div_clear;
    s_warm_exit |-> div_q == '0 && resume_next;
  endproperty
  a_div_clear: assert property (p_div_clear)
    else $error("divider not cleared at stop release");

  property p_idle_service;
    state == SCSC_IDLE && irq_req && interrupt_master_enable
      |=> irq_service && !resume_next && cpu_run;
  endproperty
  a_idle_service: assert property (p_idle_service)
    else $error("idle interrupt not serviced");

  property p_idle_resume;
    state == SCSC_IDLE && irq_req && !interrupt_master_enable
      |=> resume_next && !irq_service;
  endproperty
  a_idle_resume: assert property (p_idle_resume)
    else $error("idle plain resume missing");

  property p_idle_enter;
    state == SCSC_NORMAL && idle_req && !stop_req
      |=> !cpu_run && !wdt_run && periph_run && osc_enable;
  endproperty
  a_idle_enter: assert property (p_idle_enter)
    else $error("idle clock gating wrong");

  property p_mc_wrap;
    cpu_run && mc_state == 2'h3 && next_state == SCSC_NORMAL
      |=> mc_state == 2'h0;
  endproperty
  a_mc_wrap: assert property (p_mc_wrap)
    else $error("machine cycle not four states");

  property p_presc_range;
    presc_q != 2'h3;
  endproperty
  a_presc_range: assert property (p_presc_range)
    else $error("prescaler left its three counts");
endmodule : scsc_top

// [verif/tb_top.sv]
// self-checking bench for the system clock and standby controller
`timescale 1ns/1ps
module tb_top;
  import scsc_pkg::*;
  localparam int WU = 4; // shortened warm-up unit keeps the run brief
  localparam logic [9:0] A_ONE = {SCSC_IDX_ONE, 2'b00};
  localparam logic [9:0] A_TWO = {SCSC_IDX_TWO, 2'b00};
  localparam logic [9:0] A_DIV = {SCSC_IDX_DIV, 2'b00};
  localparam logic [9:0] A_STAT = {SCSC_IDX_STATUS, 2'b00};
  localparam logic [9:0] A_BAD = 10'h3C0;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [9:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic stop_pin = 1'b0;
  logic reset_pin_n = 1'b1;
  logic irq_req = 1'b0;
  logic interrupt_master_enable = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, osc_enable, cpu_run, wdt_run, periph_run;
  logic fc8_out, irq_service, resume_next;
  logic [1:0] s_axi_bresp, s_axi_rresp, mc_state, mode;
  logic [31:0] s_axi_rdata;
  int miscompares = 0;
  int cmp_count = 0;

  scsc_top #(.WU_UNIT(WU)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_pin,
    .reset_pin_n, .irq_req, .interrupt_master_enable, .osc_enable,
    .cpu_run, .wdt_run, .periph_run, .mc_state, .fc8_out, .irq_service,
    .resume_next, .mode);

  // free-running 100 MHz clock
  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic fail(input string m);
    miscompares++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask : chk_bit

  task automatic chk_two(input logic [1:0] got, input logic [1:0] exp,
                         input string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask : chk_two

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                          input string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask : chk_word

  // one edge with a bound, so no wait can hang the run
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 3000) begin
      fail("wait bound exhausted");
      wrap_up();
    end
  endtask : step

  ////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [9:0] a, input logic [7:0] d,
                           output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      step(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [9:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      step(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  task automatic reg_expect(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk_two(r, SCSC_RESP_OKAY, "read response");
    chk_word(d, {24'h00_0000, e}, "register value");
  endtask : reg_expect

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk_two(r, SCSC_RESP_OKAY, "write response");
  endtask : wr

  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (mode !== m) step(n);
  endtask : wait_mode

  // counts cycles spent warming up, then checks the resume
  task automatic measure(input int exp);
    int n;
    int k;
    n = 0;
    k = 0;
    chk_bit(osc_enable, 1'b1, "oscillator off in warm-up");
    while (mode === SCSC_WARMUP) begin
      k++;
      step(n);
    end
    chk_word(k, exp, "warm-up length");
    chk_two(mode, SCSC_NORMAL, "no return to normal");
    chk_bit(resume_next, 1'b1, "no resume after warm-up");
  endtask : measure

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    reg_expect(A_ONE, 8'h00);
    reg_expect(A_TWO, 8'h80);
    reg_expect(A_DIV, 8'h02);
    axi_write(A_BAD, 8'h55, r);
    chk_two(r, SCSC_RESP_SLVERR, "unmapped write");
    axi_read(A_BAD, d, r);
    chk_two(r, SCSC_RESP_SLVERR, "unmapped read");
  endtask : t_regs

  task automatic t_clocks();
    logic [1:0] p;
    int k;
    p = mc_state;
    repeat (8) begin
      @(posedge aclk);
      chk_two(mc_state, p + 2'h1, "state sequence");
      p = mc_state;
    end
    k = 0;
    repeat (8) begin
      @(posedge aclk);
      k += int'(fc8_out === 1'b1);
    end
    chk_word(k, 4, "half rate output");
    wr(A_DIV, 8'h00);
    repeat (2) @(posedge aclk);
    k = 0;
    repeat (8) begin
      @(posedge aclk);
      k += int'(fc8_out === 1'b1);
    end
    chk_word(k, 8, "full rate output");
  endtask : t_clocks

  // both release flavours of idle, enable high then low
  task automatic t_idle();
    int n;
    for (int i = 0; i < 2; i++) begin
      wr(A_TWO, 8'h90);
      wait_mode(SCSC_IDLE);
      chk_bit(cpu_run, 1'b0, "core runs in idle");
      chk_bit(wdt_run, 1'b0, "watchdog runs in idle");
      chk_bit(periph_run, 1'b1, "peripherals stopped");
      chk_bit(osc_enable, 1'b1, "oscillator stopped");
      interrupt_master_enable <= (i == 0);
      irq_req <= 1'b1;
      n = 0;
      while (irq_service !== 1'b1 && resume_next !== 1'b1) step(n);
      irq_req <= 1'b0;
      chk_bit(irq_service, i == 0, "service pulse");
      chk_bit(resume_next, i != 0, "resume pulse");
      chk_two(mode, SCSC_NORMAL, "idle not left");
      chk_bit(cpu_run, 1'b1, "core still stopped");
      reg_expect(A_TWO, 8'h80);
    end
  endtask : t_idle

  task automatic t_stop_edge();
    stop_pin <= 1'b1;
    wr(A_ONE, 8'h9C);
    wait_mode(SCSC_STOP);
    chk_bit(osc_enable, 1'b0, "oscillator on in stop");
    chk_bit(periph_run, 1'b0, "peripherals run in stop");
    reg_expect(A_STAT, 8'h0A);
    repeat (4) @(posedge aclk);
    chk_two(mode, SCSC_STOP, "high level released edge mode");
    stop_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    chk_two(mode, SCSC_STOP, "falling edge released");
    stop_pin <= 1'b1;
    wait_mode(SCSC_WARMUP);
    measure(WU);
    reg_expect(A_ONE, 8'h1C);
  endtask : t_stop_edge

  // level mode with the pin already high skips straight to warm-up
  task automatic t_stop_level();
    int mul[4] = '{12, 4, 3, 1};
    int n;
    wr(A_DIV, 8'h12);
    for (int s = 0; s < 4; s++) begin
      wr(A_ONE, 8'hD0 | 8'(s << 2));
      n = 0;
      while (mode === SCSC_NORMAL) step(n);
      chk_two(mode, SCSC_WARMUP, "level mode entered stop");
      measure(mul[s] * WU * 2);
    end
  endtask : t_stop_level

  // level release from stop, then reset pin out of stop
  task automatic t_reset_pin();
    stop_pin <= 1'b0;
    wr(A_ONE, 8'hD0);
    wait_mode(SCSC_STOP);
    stop_pin <= 1'b1;
    wait_mode(SCSC_WARMUP);
    measure(12 * WU * 2);
    stop_pin <= 1'b0;
    wr(A_ONE, 8'hD0);
    wait_mode(SCSC_STOP);
    reset_pin_n <= 1'b0;
    @(posedge aclk);
    reset_pin_n <= 1'b1;
    @(posedge aclk);
    chk_two(mode, SCSC_NORMAL, "reset pin kept stop");
    chk_bit(osc_enable, 1'b1, "oscillator off after reset");
    reg_expect(A_ONE, 8'h00);
    reg_expect(A_DIV, 8'h02);
  endtask : t_reset_pin

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_clocks();
    t_idle();
    t_stop_edge();
    t_stop_level();
    t_reset_pin();
    wrap_up();
  end
endmodule : tb_top
